// ===== hdl/chan_seq_pkg.sv
// Constants shared by the channel memory and scan sequencer.
// Assumes one 50 MHz clock and a classic Wishbone front-panel host.
//
// Overview of operation
// - first and last channel limited 00..99
// - hundred entries: function, value, two limits
// - confirming first channel returns to memory setup
// - memory setup clears automatic ranging
// - memory setup forces standby, blocks output
// - enter or range change loads default limits
// - enter in memory setup advances channel
// - channel key selects keyed channel directly
// - clear-entry discards keyed value only
// - opening channel presets zero, default limits
// - four recall methods: direct, step, scans
// - recall key toggles recall state
// - recall with output on drives channel
// - step mode advances one per start
// - single scan runs first to last once
// - repeat scan restarts from first continuously
// - step time whole seconds 1..99
// - single scan end: lamp off, first, output
// - start pauses scan, again resumes there
// - step after last wraps to first
package chan_seq_pkg;
    localparam int CHANNELS = 100;
    localparam logic [6:0] CH_MAX = 7'h63;
    localparam logic [6:0] STEP_MIN = 7'h01;
    localparam logic [6:0] STEP_MAX = 7'h63;
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 1000000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // Word offsets on the bus, byte addresses
    localparam logic [7:0] OFS_KEY = 8'h00;
    localparam logic [7:0] OFS_ENTRY = 8'h04;
    localparam logic [7:0] OFS_FUNC = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_SCAN = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Key codes written to the key register
    localparam logic [3:0] KEY_MEMORY = 4'h1;
    localparam logic [3:0] KEY_RECALL = 4'h2;
    localparam logic [3:0] KEY_ENTER = 4'h3;
    localparam logic [3:0] KEY_CHANNEL = 4'h4;
    localparam logic [3:0] KEY_CLEAR = 4'h5;
    localparam logic [3:0] KEY_START = 4'h6;
    localparam logic [3:0] KEY_HOME = 4'h7;
    localparam logic [3:0] KEY_RANGE = 4'h8;
    localparam logic [3:0] KEY_LIMIT = 4'h9;
    localparam logic [3:0] KEY_OUTPUT = 4'hA;
    localparam logic [3:0] KEY_OPEN = 4'hB;
    localparam logic [3:0] KEY_FIRST = 4'hC;
    localparam logic [3:0] KEY_LAST = 4'hD;
    // Field positions and reset values
    localparam int SCAN_STEP_LSB = 8;
    localparam logic [1:0] RECALL_STEP = 2'h0;
    localparam logic [1:0] single_scan_mode = 2'h1;
    localparam logic [1:0] repeat_scan_mode = 2'h2;
    localparam logic [6:0] STEP_RESET = 7'h01;
    localparam logic [6:0] END_RESET = 7'h63;
    localparam logic [23:0] ZERO_VALUE = 24'h00_0000;
    localparam logic [15:0] DEF_VLIM = 16'h0100;
    localparam logic [15:0] DEF_ILIM = 16'h0100;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MEM = 4'b0010,
        ST_FLSET = 4'b0100,
        ST_RECALL = 4'b1000
    } panel_state_t;
endpackage

// ===== hdl/chan_scan_seq.sv
// Channel program memory with memory setup, recall and scan sequencing.
// Assumes the front-panel controller is a classic Wishbone master and
// the output stage latches the OUT_* bundle whenever OUT_ENABLE is high.
module chan_scan_seq
    import chan_seq_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic MCLK,            // 50 MHz system clock
    input wire logic RST,             // Asynchronous reset, active high
    input wire logic CYC_I,           // Wishbone cycle
    input wire logic STB_I,           // Wishbone strobe
    input wire logic WE_I,            // Wishbone write enable
    input wire logic [7:0] ADR_I,     // Wishbone byte address
    input wire logic [3:0] SEL_I,     // Wishbone byte selects
    input wire logic [31:0] DAT_I,    // Wishbone write data
    output logic [31:0] DAT_O,        // Wishbone read data
    output logic ACK_O,               // Wishbone acknowledge
    output logic [1:0] OUT_FUNC,      // Recalled function
    output logic [23:0] OUT_VALUE,    // Recalled output value
    output logic [15:0] OUT_VLIM,     // Recalled voltage limit
    output logic [15:0] OUT_ILIM,     // Recalled current limit
    output logic OUT_ENABLE,          // Output stage operate
    output logic AUTO_RANGE,          // Automatic ranging allowed
    output logic START_LAMP,          // Start indicator lit
    output logic LAMP_BLINK           // Start indicator blinking
);
    panel_state_t state_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [23:0] entry_reg;
    logic [1:0] efunc_reg;
    logic [15:0] evlim_reg;
    logic [15:0] eilim_reg;
    logic [1:0] mode_reg;
    logic [6:0] step_reg;
    logic [6:0] start_ch_reg;
    logic [6:0] scan_end_channel_reg;
    logic fl_last_reg;
    logic [6:0] chan_reg;
    logic [6:0] chan_next;
    logic out_on_reg;
    logic auto_reg;
    logic run_reg;
    logic pause_reg;
    logic stepped_reg;
    logic [25:0] tick_cnt_reg;
    logic tick_reg;
    logic [6:0] sec_reg;
    logic [1:0] mem_func [CHANNELS];
    logic [23:0] mem_val [CHANNELS];
    logic [15:0] mem_vlim [CHANNELS];
    logic [15:0] mem_ilim [CHANNELS];
    logic wb_req;
    logic wb_wr;
    logic key_evt;
    logic [3:0] key;
    logic in_mem;
    logic in_rec;
    logic scan_mode;
    logic step_due;
    logic at_end;

    assign wb_req = CYC_I & STB_I & ~ack_reg;
    // Partial-word writes are acknowledged but have no effect
    // Writes commit at the edge where the master samples ack
    assign wb_wr = CYC_I & STB_I & ack_reg & WE_I & (SEL_I == 4'hF);
    assign key_evt = wb_wr & (ADR_I == OFS_KEY);
    assign key = DAT_I[3:0];
    assign in_mem = (state_reg == ST_MEM);
    assign in_rec = (state_reg == ST_RECALL);
    assign scan_mode = (mode_reg == single_scan_mode) |
                       (mode_reg == repeat_scan_mode);
    assign step_due = tick_reg & run_reg & ~pause_reg & (sec_reg >= step_reg);
    assign at_end = (chan_reg == scan_end_channel_reg);
    assign chan_next = (chan_reg == CH_MAX) ? 7'h00 : chan_reg + 7'h01;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= wb_req;
            if (wb_req && !WE_I)
            begin
                unique case (ADR_I)
                    OFS_ENTRY: rdata_reg <= {8'h00, entry_reg};
                    OFS_FUNC: rdata_reg <= {30'h0000_0000, efunc_reg};
                    OFS_LIMIT: rdata_reg <= {eilim_reg, evlim_reg};
                    OFS_SCAN: rdata_reg <= {17'h0_0000, step_reg,
                                            6'h00, mode_reg};
                    OFS_STATUS: rdata_reg <= {1'b0, scan_end_channel_reg,
                        1'b0, start_ch_reg, 1'b0, chan_reg,
                        pause_reg, run_reg, out_on_reg, auto_reg,
                        state_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Keyed entry and limit holding registers
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            entry_reg <= ZERO_VALUE;
            efunc_reg <= 2'h0;
            evlim_reg <= DEF_VLIM;
            eilim_reg <= DEF_ILIM;
        end
        else if (key_evt && key == KEY_CLEAR)
            entry_reg <= ZERO_VALUE;
        else if (key_evt && key == KEY_OPEN)
            entry_reg <= ZERO_VALUE;
        else if (wb_wr)
        begin
            if (ADR_I == OFS_ENTRY)
                entry_reg <= DAT_I[23:0];
            if (ADR_I == OFS_FUNC)
                efunc_reg <= DAT_I[1:0];
            if (ADR_I == OFS_LIMIT)
            begin
                evlim_reg <= DAT_I[15:0];
                eilim_reg <= DAT_I[31:16];
            end
        end
    end

    // Mode selectable anywhere; step time only during memory setup
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            mode_reg <= RECALL_STEP;
            step_reg <= STEP_RESET;
        end
        else if (wb_wr && ADR_I == OFS_SCAN)
        begin
            if (DAT_I[1:0] != 2'h3)
                mode_reg <= DAT_I[1:0];
            if (in_mem && DAT_I[SCAN_STEP_LSB +: 7] >= STEP_MIN &&
                DAT_I[SCAN_STEP_LSB +: 7] <= STEP_MAX)
                step_reg <= DAT_I[SCAN_STEP_LSB +: 7];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (key_evt && in_mem)
        begin
            if (key == KEY_OPEN)
            begin
                mem_val[chan_reg] <= ZERO_VALUE;
                mem_vlim[chan_reg] <= DEF_VLIM;
                mem_ilim[chan_reg] <= DEF_ILIM;
            end
            if (key == KEY_ENTER)
            begin
                mem_func[chan_reg] <= efunc_reg;
                mem_val[chan_reg] <= entry_reg;
                mem_vlim[chan_reg] <= DEF_VLIM;
                mem_ilim[chan_reg] <= DEF_ILIM;
            end
            if (key == KEY_RANGE)
            begin
                mem_vlim[chan_reg] <= DEF_VLIM;
                mem_ilim[chan_reg] <= DEF_ILIM;
            end
            if (key == KEY_LIMIT)
            begin
                mem_vlim[chan_reg] <= evlim_reg;
                mem_ilim[chan_reg] <= eilim_reg;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            tick_cnt_reg <= 26'h000_0000;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (tick_cnt_reg == 26'(TICK_LEN - 1));
            if (tick_cnt_reg == 26'(TICK_LEN - 1))
                tick_cnt_reg <= 26'h000_0000;
            else
                tick_cnt_reg <= tick_cnt_reg + 26'h000_0001;
        end
    end

    // Panel state, channel pointer and scan control
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= ST_IDLE;
            chan_reg <= 7'h00;
            start_ch_reg <= 7'h00;
            scan_end_channel_reg <= END_RESET;
            fl_last_reg <= 1'b0;
            out_on_reg <= 1'b0;
            auto_reg <= 1'b1;
            run_reg <= 1'b0;
            pause_reg <= 1'b0;
            stepped_reg <= 1'b0;
            sec_reg <= 7'h00;
        end
        else if (key_evt)
        begin
            unique case (state_reg)
                ST_IDLE, ST_RECALL:
                begin
                    if (key == KEY_MEMORY)
                    begin
                        auto_reg <= 1'b0;
                        out_on_reg <= 1'b0;
                        run_reg <= 1'b0;
                        pause_reg <= 1'b0;
                        stepped_reg <= 1'b0;
                        chan_reg <= 7'h00;
                        state_reg <= ST_MEM;
                    end
                    else if (key == KEY_RECALL)
                    begin
                        state_reg <= in_rec ? ST_IDLE : ST_RECALL;
                        run_reg <= 1'b0;
                        pause_reg <= 1'b0;
                        stepped_reg <= 1'b0;
                    end
                    else if (key == KEY_OUTPUT)
                        out_on_reg <= ~out_on_reg;
                    else if (key == KEY_CHANNEL && entry_reg[6:0] <= CH_MAX
                             && entry_reg[23:7] == 17'h0_0000)
                        chan_reg <= entry_reg[6:0];
                    else if (key == KEY_HOME && in_rec)
                    begin
                        run_reg <= 1'b0;
                        pause_reg <= 1'b0;
                        stepped_reg <= 1'b0;
                        chan_reg <= start_ch_reg;
                    end
                    else if (key == KEY_START && in_rec && !scan_mode)
                    begin
                        stepped_reg <= 1'b1;
                        if (!stepped_reg || at_end)
                            chan_reg <= start_ch_reg;
                        else
                            chan_reg <= chan_next;
                    end
                    else if (key == KEY_START && in_rec)
                    begin
                        if (!run_reg)
                        begin
                            run_reg <= 1'b1;
                            stepped_reg <= 1'b0;
                            chan_reg <= start_ch_reg;
                            // First hold starts in a partial second
                            sec_reg <= 7'h01;
                        end
                        else
                            pause_reg <= ~pause_reg;
                    end
                end
                ST_MEM:
                begin
                    if (key == KEY_MEMORY)
                        state_reg <= ST_IDLE;
                    else if (key == KEY_ENTER)
                        chan_reg <= chan_next;
                    else if (key == KEY_CHANNEL && entry_reg[6:0] <= CH_MAX
                             && entry_reg[23:7] == 17'h0_0000)
                        chan_reg <= entry_reg[6:0];
                    else if (key == KEY_FIRST || key == KEY_LAST)
                    begin
                        fl_last_reg <= (key == KEY_LAST);
                        state_reg <= ST_FLSET;
                    end
                end
                ST_FLSET:
                begin
                    if (key == KEY_ENTER)
                    begin
                        if (entry_reg <= {17'h0_0000, CH_MAX})
                        begin
                            if (fl_last_reg)
                                scan_end_channel_reg <= entry_reg[6:0];
                            else
                                start_ch_reg <= entry_reg[6:0];
                        end
                        state_reg <= ST_MEM;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
        else if (tick_reg && run_reg && !pause_reg)
        begin
            if (!step_due)
                sec_reg <= sec_reg + 7'h01;
            else
            begin
                sec_reg <= 7'h01;
                if (!at_end)
                    chan_reg <= chan_next;
                else if (mode_reg == repeat_scan_mode)
                    chan_reg <= start_ch_reg;
                else
                begin
                    run_reg <= 1'b0;
                    chan_reg <= start_ch_reg;
                    out_on_reg <= 1'b1;
                end
            end
        end
    end

    // Output stage bundle, registered
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            OUT_FUNC <= 2'h0;
            OUT_VALUE <= ZERO_VALUE;
            OUT_VLIM <= 16'h0000;
            OUT_ILIM <= 16'h0000;
            OUT_ENABLE <= 1'b0;
            AUTO_RANGE <= 1'b1;
            START_LAMP <= 1'b0;
            LAMP_BLINK <= 1'b0;
        end
        else
        begin
            OUT_ENABLE <= in_rec & out_on_reg;
            if (in_rec && out_on_reg)
            begin
                OUT_FUNC <= mem_func[chan_reg];
                OUT_VALUE <= mem_val[chan_reg];
                OUT_VLIM <= mem_vlim[chan_reg];
                OUT_ILIM <= mem_ilim[chan_reg];
            end
            AUTO_RANGE <= auto_reg;
            START_LAMP <= run_reg | stepped_reg;
            LAMP_BLINK <= pause_reg;
        end
    end

    assign DAT_O = rdata_reg;
    assign ACK_O = ack_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    property p_mem_standby;
        in_mem |-> !out_on_reg ##1 !OUT_ENABLE;
    endproperty
    a_mem_standby: assert property (p_mem_standby)
        else $error("output active in memory setup");
    property p_mem_manual;
        in_mem |-> !auto_reg;
    endproperty
    a_mem_manual: assert property (p_mem_manual)
        else $error("auto range during memory setup");
    property p_bounds;
        chan_reg <= CH_MAX && start_ch_reg <= CH_MAX &&
        scan_end_channel_reg <= CH_MAX;
    endproperty
    a_bounds: assert property (p_bounds)
        else $error("channel outside 0..99");
    property p_step_range;
        step_reg >= STEP_MIN && step_reg <= STEP_MAX;
    endproperty
    a_step_range: assert property (p_step_range)
        else $error("step time outside 1..99");
    property p_enter_adv;
        key_evt && in_mem && key == KEY_ENTER |=>
            chan_reg == (($past(chan_reg) == CH_MAX) ? 7'h00 :
                         $past(chan_reg) + 7'h01);
    endproperty
    a_enter_adv: assert property (p_enter_adv)
        else $error("enter did not advance channel");
    property p_recall_toggle;
        key_evt && key == KEY_RECALL && state_reg == ST_IDLE
            |=> in_rec;
    endproperty
    a_recall_toggle: assert property (p_recall_toggle)
        else $error("recall key did not enter recall");
    property p_clear;
        key_evt && key == KEY_CLEAR |=> entry_reg == ZERO_VALUE;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear entry left a value");
    property p_fl_return;
        key_evt && key == KEY_ENTER && state_reg == ST_FLSET |=> in_mem;
    endproperty
    a_fl_return: assert property (p_fl_return)
        else $error("setup did not return to memory");
    property p_pause;
        key_evt && key == KEY_START && in_rec && scan_mode &&
        run_reg && !pause_reg |=> pause_reg ##1 LAMP_BLINK;
    endproperty
    a_pause: assert property (p_pause)
        else $error("start did not pause scan");
    property p_single_end;
        step_due && at_end && mode_reg == single_scan_mode && !key_evt
            |=> !run_reg && chan_reg == start_ch_reg ##1 !START_LAMP;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("single scan did not finish");
    c_repeat_wrap: cover property (step_due && at_end &&
                                   mode_reg == repeat_scan_mode);
    c_resume: cover property (pause_reg ##[1:20] !pause_reg && run_reg);
    c_step_wrap: cover property (key_evt && key == KEY_START &&
                                 stepped_reg && at_end && !scan_mode);
endmodule

// ===== tb/out_stage_model.sv
// Output stage model: applies the recalled value while operating.
// Assumes the generator's OUT_* bundle and the same clock and reset.
module out_stage_model
(
    input wire logic clk,             // System clock
    input wire logic rst,             // Reset, active high
    input wire logic en,              // Operate request
    input wire logic [23:0] value_in, // Setting offered by the generator
    output logic [23:0] applied       // Value on the terminals
);
    timeunit 1ns;
    timeprecision 1ns;

    // Standby keeps the last applied value, as a relay stage would
    always_ff @(posedge clk or posedge rst)
        if (rst)
            applied <= 24'h00_0000;
        else if (en)
            applied <= value_in;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the channel memory and scan sequencer.
// Assumes the Wishbone map and key codes of chan_seq_pkg.
module tb
    import chan_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TL = 20;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o, rdata;
    logic ack, oen, auto_r, lamp, blink;
    logic [1:0] ofunc;
    logic [23:0] oval, applied;
    logic [15:0] ovlim, oilim;
    logic [23:0] ev [4] = '{24'h00_0000, 24'h00_0101, 24'h00_0102,
                            24'h00_0103};
    int miscompares = 0;
    int n_checks = 0;

    always #10 MCLK = ~MCLK;

    // Short tick so a whole scan fits in a few hundred cycles
    chan_scan_seq #(.TICK_LEN(TL)) dut_u (.MCLK(MCLK), .RST(RST),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .OUT_FUNC(ofunc),
        .OUT_VALUE(oval), .OUT_VLIM(ovlim), .OUT_ILIM(oilim),
        .OUT_ENABLE(oen), .AUTO_RANGE(auto_r), .START_LAMP(lamp),
        .LAMP_BLINK(blink));

    out_stage_model stage_u (.clk(MCLK), .rst(RST), .en(oen),
        .value_in(oval), .applied(applied));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One classic cycle; ack is awaited, never assumed
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        @(posedge MCLK);
        while (ack !== 1'b1 && n < 40)
        begin
            @(posedge MCLK);
            n++;
        end
        if (n >= 40)
            miscompares++;
        rdata = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Outputs follow the state one edge later, the stage model one more
    task automatic key(input logic [3:0] k);
        bus(1'b1, OFS_KEY, {28'h000_0000, k});
        repeat (3) @(negedge MCLK);
    endtask

    task automatic status(input logic [31:0] exp);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rdata, exp);
    endtask

    function automatic logic [31:0] st(logic [3:0] s, logic [3:0] f,
        logic [6:0] ch, logic [6:0] fi, logic [6:0] la);
        return {1'b0, la, 1'b0, fi, 1'b0, ch, f, s};
    endfunction

    initial
    begin
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        chk(32'(auto_r), 32'h0000_0001);
        status(st(4'h1, 4'h1, 7'h00, 7'h00, 7'h63));
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rdata, 32'h0000_0000);
        key(KEY_MEMORY);
        chk(32'(auto_r), 32'h0000_0000);
        status(st(4'h2, 4'h0, 7'h00, 7'h00, 7'h63));
        key(KEY_OUTPUT);
        chk(32'(oen), 32'h0000_0000);
        bus(1'b1, OFS_SCAN, 32'h0000_0201);
        key(KEY_OPEN);
        key(KEY_ENTER);
        for (int c = 1; c < 4; c++)
        begin
            bus(1'b1, OFS_FUNC, 32'(c - 1));
            bus(1'b1, OFS_ENTRY, 32'(ev[c]));
            key(KEY_ENTER);
        end
        status(st(4'h2, 4'h0, 7'h04, 7'h00, 7'h63));
        bus(1'b1, OFS_LIMIT, 32'h0022_0011);
        for (int c = 2; c < 4; c++)
        begin
            bus(1'b1, OFS_ENTRY, 32'(c));
            key(KEY_CHANNEL);
            key(KEY_LIMIT);
            // Range change on channel 2 must restore the defaults
            if (c == 2)
                key(KEY_RANGE);
        end
        bus(1'b1, OFS_ENTRY, 32'h0000_0001);
        key(KEY_FIRST);
        status(st(4'h4, 4'h0, 7'h03, 7'h00, 7'h63));
        key(KEY_ENTER);
        status(st(4'h2, 4'h0, 7'h03, 7'h01, 7'h63));
        bus(1'b1, OFS_ENTRY, 32'h0000_0003);
        key(KEY_LAST);
        key(KEY_ENTER);
        // Out-of-range channel must leave the last channel as it was
        bus(1'b1, OFS_ENTRY, 32'h0000_0064);
        key(KEY_LAST);
        key(KEY_ENTER);
        status(st(4'h2, 4'h0, 7'h03, 7'h01, 7'h03));
        key(KEY_MEMORY);
        key(KEY_RECALL);
        key(KEY_OUTPUT);
        chk(32'(oen), 32'h0000_0001);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, OFS_ENTRY, 32'(c));
            key(KEY_CHANNEL);
            chk(32'(applied), 32'(ev[c]));
            chk(32'(ovlim), c == 3 ? 32'h11 : 32'(DEF_VLIM));
            chk(32'(oilim), c == 3 ? 32'h22 : 32'(DEF_ILIM));
            chk(32'(ofunc), c == 0 ? 32'h0 : 32'(c - 1));
        end
        bus(1'b1, OFS_SCAN, 32'(RECALL_STEP));
        for (int i = 0; i < 4; i++)
        begin
            key(KEY_START);
            chk(32'(applied), 32'(ev[(i % 3) + 1]));
        end
        key(KEY_HOME);
        bus(1'b1, OFS_SCAN, 32'(single_scan_mode));
        key(KEY_START);
        chk(32'(lamp), 32'h0000_0001);
        repeat (45) @(negedge MCLK);
        chk(32'(applied), 32'(ev[2]));
        repeat (45) @(negedge MCLK);
        chk(32'(applied), 32'(ev[3]));
        repeat (60) @(negedge MCLK);
        chk(32'({lamp, oen, applied}), 32'({2'b01, ev[1]}));
        bus(1'b1, OFS_SCAN, 32'(repeat_scan_mode));
        key(KEY_START);
        repeat (90) @(negedge MCLK);
        chk(32'(applied), 32'(ev[3]));
        repeat (32) @(negedge MCLK);
        chk(32'(applied), 32'(ev[1]));
        key(KEY_START);
        chk(32'({lamp, blink}), 32'h0000_0003);
        repeat (100) @(negedge MCLK);
        chk(32'(applied), 32'(ev[1]));
        key(KEY_START);
        chk(32'({blink, lamp, applied}), 32'({2'b01, ev[1]}));
        key(KEY_RECALL);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(32'({rdata[3:0], oen}), 32'h0000_0002);
        finish_test();
    end

    // Whole run is under 1000 cycles; twenty times that means a hang
    initial
    begin
        repeat (20000) @(posedge MCLK);
        miscompares++;
        finish_test();
    end
endmodule
